// >>> rtl/sdram_pkg.sv
// Shared constants, command codes and helpers for the SDRAM link.
// Assumes a single 50 MHz clock on both ends.
package sdram_pkg;
	localparam int BANKS = 4;
	localparam int BANK_W = 2;
	localparam int ROW_W = 12;
	localparam int ADDR_W = 12;
	localparam int COL_W = 9;
	localparam int DATA_W = 16;
	localparam int MEM_COL_W = 8;
	localparam int MEM_IDX_W = 10;
	localparam int MEM_WORDS = 1024;
	localparam int BEAT_W = 10;
	localparam int AP_BIT = 10;
	localparam int MODE_BL_LSB = 0;
	localparam int MODE_CL_LSB = 4;
	localparam logic [2:0] BL_1 = 3'h0;
	localparam logic [2:0] BL_2 = 3'h1;
	localparam logic [2:0] BL_4 = 3'h2;
	localparam logic [2:0] BL_8 = 3'h3;
	localparam logic [2:0] BL_PAGE = 3'h7;
	localparam logic [2:0] CL_2 = 3'h2;
	localparam logic [2:0] CL_3 = 3'h3;
	localparam logic [BEAT_W-1:0] PAGE_BEATS = 10'h200;
	localparam logic [BEAT_W-1:0] PAGE_READ_BEATS = 10'h010;
	typedef enum logic [2:0] {
		CMD_LMR = 3'h0,
		CMD_REF = 3'h1,
		CMD_PRE = 3'h2,
		CMD_ACT = 3'h3,
		CMD_WR = 3'h4,
		CMD_RD = 3'h5,
		CMD_BST = 3'h6,
		CMD_NOP = 3'h7
	} cmd_t;
	localparam int CLK_PERIOD_NS = 20;
	localparam int REFRESH_INTERVAL_NS = 15625;
	localparam int REFRESH_CYCLES = REFRESH_INTERVAL_NS / CLK_PERIOD_NS;
	localparam int FIFO_DEPTH = 16;
	localparam int LEVEL_W = 5;
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_RDATA = 8'h10;
	localparam logic [7:0] REG_CFG = 8'h14;
	localparam logic [1:0] OP_READ = 2'h1;
	localparam logic [1:0] OP_WRITE = 2'h2;
	localparam int ADDR_ROW_LSB = 9;
	localparam int ADDR_BANK_LSB = 21;
	localparam int CFG_CL3_BIT = 4;
	localparam int CFG_SLEEP_BIT = 8;
	localparam int STAT_SLEEP_BIT = 1;
	localparam int STAT_LEVEL_LSB = 4;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;

	function automatic logic [BEAT_W-1:0] burst_beats(input logic [2:0] code);
		case (code)
			BL_1: burst_beats = 10'h001;
			BL_2: burst_beats = 10'h002;
			BL_4: burst_beats = 10'h004;
			BL_8: burst_beats = 10'h008;
			BL_PAGE: burst_beats = PAGE_BEATS;
			default: burst_beats = 10'h001;
		endcase
	endfunction
endpackage

// >>> rtl/sdram_if.sv
// Pin bundle between memory controller and SDRAM device.
// The shared data bus is resolved here from the two drive enables.
`timescale 1ns/1ps
interface sdram_if;
	import sdram_pkg::*;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic cke;
	logic bank_select_0;
	logic bank_select_1;
	logic [ADDR_W-1:0] addr;
	logic low_byte_mask;
	logic high_byte_mask;
	logic [DATA_W-1:0] ctl_dq_o;
	logic ctl_dq_oe;
	logic [DATA_W-1:0] dev_dq_o;
	logic dev_dq_oe;
	logic [DATA_W-1:0] dq;

	assign dq = dev_dq_oe ? dev_dq_o : (ctl_dq_oe ? ctl_dq_o : 16'h0000);

	modport ctl (
		output cs_n, ras_n, cas_n, we_n, cke, bank_select_0, bank_select_1, addr,
		output low_byte_mask, high_byte_mask, ctl_dq_o, ctl_dq_oe,
		input dev_dq_oe, dq
	);
	modport mem (
		input cs_n, ras_n, cas_n, we_n, cke, bank_select_0, bank_select_1, addr,
		input low_byte_mask, high_byte_mask, dq,
		output dev_dq_o, dev_dq_oe
	);
endinterface

// >>> rtl/sync_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Depth must be a power of two; one clock domain.
`timescale 1ns/1ps
module sync_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data,
	output logic [$clog2(DEPTH):0] o_level
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] buf_mem [0:DEPTH-1];
	logic [PW-1:0] wr_ptr_reg;
	logic [PW-1:0] rd_ptr_reg;
	logic [PW:0] count_reg;
	logic push;
	logic pop;

	assign o_in_ready = count_reg != (PW+1)'(DEPTH);
	assign o_out_valid = count_reg != '0;
	assign o_out_data = buf_mem[rd_ptr_reg];
	assign o_level = count_reg;
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;

	always_ff @(posedge i_clk)
	begin
		if (push)
			buf_mem[wr_ptr_reg] <= i_in_data;
	end

	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end
endmodule

// >>> rtl/sdram_mem.sv
// Quad-bank SDRAM device end: command decode, banks, bursts, read pipe.
// Expects the controller to keep command order; only the x16 build is modelled
// and storage aliases on row and the top column bit.
//
// Contract
// [RL1] Every pin sampled at rising clock edge
// [RL2] Burst length one, two, four, eight, page
// [RL3] Controller activates row before read or write
// [RL4] Active picks bank and twelve-bit row
// [RL5] Column from command, rest generated internally
// [RL6] 4096 rows; 2048/1024/512 columns per build
// [RL7] Auto precharge closes row after burst
// [RL8] Burst terminate ends burst early
// [RL9] New column command accepted every cycle
// [RL10] Controller refreshes every 15.625 microseconds
// [RL11] Precharge one bank while another transfers
// [RL12] Self refresh keeps data without commands
// [RL13] Read data after latency two or three
// [RL14] Commands encoded on four strobe pins
`timescale 1ns/1ps
module sdram_mem
	import sdram_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_nrst,
	output logic o_self_refresh,
	sdram_if.mem m
);
	typedef enum logic [1:0] {
		S_RUN = 2'b01,
		S_SELF = 2'b10
	} mem_state_t;

	logic [DATA_W-1:0] mem_array [0:MEM_WORDS-1];
	mem_state_t state_reg;
	logic [BANKS-1:0] open_reg;
	logic [ROW_W-1:0] row_reg [0:BANKS-1]; // [RL6]
	logic [2:0] bl_code_reg;
	logic cl3_reg;
	logic burst_on_reg;
	logic burst_wr_reg;
	logic burst_ap_reg;
	logic [BANK_W-1:0] burst_bank_reg;
	logic [COL_W-1:0] burst_base_reg;
	logic [BEAT_W-1:0] burst_n_reg;
	logic [DATA_W-1:0] pipe0_d_reg;
	logic pipe0_v_reg;
	logic [DATA_W-1:0] pipe1_d_reg;
	logic pipe1_v_reg;
	logic [DATA_W-1:0] dq_o_reg;
	logic dq_oe_reg;
	logic self_reg;

	cmd_t cmd;
	logic sel;
	logic [BANK_W-1:0] bank;
	logic [BEAT_W-1:0] beats;
	logic is_col;
	logic is_bst;
	logic beat;
	logic beat_wr;
	logic last;
	logic [BANK_W-1:0] beat_bank;
	logic [COL_W-1:0] beat_col;
	logic close_old;
	logic close_new;
	logic [MEM_IDX_W-1:0] idx;

	function automatic logic [COL_W-1:0] col_seq(
		input logic [COL_W-1:0] base,
		input logic [BEAT_W-1:0] n,
		input logic [BEAT_W-1:0] len
	);
		logic [COL_W-1:0] mask;
		mask = COL_W'(len - 1'b1);
		col_seq = (base & ~mask) | ((base + n[COL_W-1:0]) & mask);
	endfunction

	assign cmd = cmd_t'({m.ras_n, m.cas_n, m.we_n}); // [RL14]
	assign sel = !m.cs_n && (state_reg == S_RUN); // [RL1]
	assign bank = {m.bank_select_1, m.bank_select_0};
	assign beats = burst_beats(bl_code_reg); // [RL2]
	assign is_col = sel && (cmd == CMD_RD || cmd == CMD_WR) && open_reg[bank]; // [RL3]
	assign is_bst = sel && (cmd == CMD_BST);
	assign idx = {beat_bank, beat_col[MEM_COL_W-1:0]};

	// Beat of this cycle: a new column command always wins over a running burst
	always_comb
	begin
		beat = 1'b0;
		beat_wr = burst_wr_reg;
		last = 1'b0;
		beat_bank = burst_bank_reg;
		beat_col = col_seq(burst_base_reg, burst_n_reg, beats); // [RL5]
		if (is_col) // [RL9]
		begin
			beat = 1'b1;
			beat_wr = (cmd == CMD_WR);
			beat_bank = bank;
			beat_col = m.addr[COL_W-1:0]; // [RL5]
			last = (beats == 10'h001);
		end
		else if (burst_on_reg && !is_bst)
		begin
			beat = 1'b1;
			last = (burst_n_reg == beats - 1'b1);
		end
	end

	// Auto-precharged row closes at burst end, on terminate, or when another access cuts in
	assign close_old = burst_on_reg && burst_ap_reg && (is_col || is_bst || last); // [RL7]
	assign close_new = is_col && last && m.addr[AP_BIT]; // [RL7]

	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			state_reg <= S_RUN;
		else
		begin
			case (state_reg)
				S_RUN:
					if (!m.cs_n && cmd == CMD_REF && !m.cke)
						state_reg <= S_SELF; // [RL12]
				S_SELF:
					if (m.cke)
						state_reg <= S_RUN; // [RL12]
				default:
					state_reg <= S_RUN;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			self_reg <= 1'b0;
		else
			self_reg <= (state_reg == S_SELF);
	end

	// Bank open state; an activate takes only a bank that was closed before the edge, and then wins over closes
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			open_reg <= '0;
			for (int b = 0; b < BANKS; b++)
				row_reg[b] <= '0;
		end
		else
		begin
			for (int b = 0; b < BANKS; b++)
			begin
				if (close_old && burst_bank_reg == BANK_W'(b))
					open_reg[b] <= 1'b0; // [RL11]
				if (close_new && bank == BANK_W'(b))
					open_reg[b] <= 1'b0;
				if (sel && cmd == CMD_PRE && (m.addr[AP_BIT] || bank == BANK_W'(b)))
					open_reg[b] <= 1'b0; // [RL11]
				if (sel && cmd == CMD_ACT && bank == BANK_W'(b) && !open_reg[b])
				begin
					open_reg[b] <= 1'b1; // [RL4]
					row_reg[b] <= m.addr[ROW_W-1:0]; // [RL4]
				end
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			bl_code_reg <= BL_1;
			cl3_reg <= 1'b0;
		end
		else if (sel && cmd == CMD_LMR && open_reg == '0)
		begin
			bl_code_reg <= m.addr[MODE_BL_LSB +: 3]; // [RL2]
			cl3_reg <= (m.addr[MODE_CL_LSB +: 3] == CL_3); // [RL13]
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			burst_on_reg <= 1'b0;
			burst_wr_reg <= 1'b0;
			burst_ap_reg <= 1'b0;
			burst_bank_reg <= '0;
			burst_base_reg <= '0;
			burst_n_reg <= '0;
		end
		else if (is_col)
		begin
			burst_on_reg <= (beats != 10'h001);
			burst_wr_reg <= (cmd == CMD_WR);
			burst_ap_reg <= m.addr[AP_BIT];
			burst_bank_reg <= bank;
			burst_base_reg <= m.addr[COL_W-1:0];
			burst_n_reg <= 10'h001;
		end
		else if (is_bst || (burst_on_reg && last))
			burst_on_reg <= 1'b0; // [RL8]
		else if (burst_on_reg)
			burst_n_reg <= burst_n_reg + 1'b1; // [RL5]
	end

	// Storage, both read pipe stages and output data register; no reset on data
	always_ff @(posedge i_clk)
	begin
		if (beat && beat_wr)
		begin
			if (!m.low_byte_mask)
				mem_array[idx][7:0] <= m.dq[7:0]; // [RL1]
			if (!m.high_byte_mask)
				mem_array[idx][15:8] <= m.dq[15:8];
		end
		pipe0_d_reg <= mem_array[idx];
		pipe1_d_reg <= pipe0_d_reg;
		dq_o_reg <= cl3_reg ? pipe1_d_reg : pipe0_d_reg; // [RL13]
	end

	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			pipe0_v_reg <= 1'b0;
			pipe1_v_reg <= 1'b0;
			dq_oe_reg <= 1'b0;
		end
		else
		begin
			pipe0_v_reg <= beat && !beat_wr;
			pipe1_v_reg <= pipe0_v_reg;
			dq_oe_reg <= cl3_reg ? pipe1_v_reg : pipe0_v_reg; // [RL13]
		end
	end

	assign m.dev_dq_o = dq_o_reg;
	assign m.dev_dq_oe = dq_oe_reg;
	assign o_self_refresh = self_reg;
endmodule

// >>> rtl/sdram_ctl.sv
// SDRAM controller end: register port for software, pin sequencing, refresh.
// Software port: one-cycle strobes, read data one cycle after the read strobe.
`timescale 1ns/1ps
module sdram_ctl
	import sdram_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	sdram_if.ctl m
);
	typedef enum logic [3:0] {
		S_IDLE = 4'b0001,
		S_ACT = 4'b0010,
		S_RUN = 4'b0100,
		S_SLEEP = 4'b1000
	} ctl_state_t;

	ctl_state_t state_reg;
	logic [1:0] op_reg;
	logic [31:0] addr_reg;
	logic [DATA_W-1:0] wdata_reg;
	logic [31:0] cfg_reg;
	logic dirty_reg;
	logic [BEAT_W-1:0] ref_cnt_reg;
	logic ref_due_reg;
	logic [BEAT_W-1:0] cnt_reg;
	logic [BEAT_W-1:0] got_reg;
	logic is_rd_reg;
	cmd_t cmd_reg;
	logic cke_reg;
	logic [BANK_W-1:0] ba_reg;
	logic [ADDR_W-1:0] a_reg;
	logic [DATA_W-1:0] dq_o_reg;
	logic dq_oe_reg;
	logic [31:0] rdata_reg;
	logic [BEAT_W-1:0] beats;
	logic [BEAT_W-1:0] free;
	logic [LEVEL_W-1:0] level;
	logic [DATA_W-1:0] head;
	logic push;
	logic pop;
	logic go_sleep;
	logic go_lmr;
	logic go_ref;
	logic go_act;

	assign beats = (cfg_reg[2:0] == BL_PAGE) ? PAGE_READ_BEATS : burst_beats(cfg_reg[2:0]);
	assign free = BEAT_W'(FIFO_DEPTH) - BEAT_W'(level);
	assign push = (state_reg == S_RUN) && is_rd_reg && m.dev_dq_oe;
	assign pop = i_rd && (i_addr == REG_RDATA);
	assign go_sleep = (state_reg == S_IDLE) && cfg_reg[CFG_SLEEP_BIT];
	assign go_lmr = (state_reg == S_IDLE) && !go_sleep && dirty_reg;
	assign go_ref = (state_reg == S_IDLE) && !go_sleep && !dirty_reg && ref_due_reg; // [RL10]
	assign go_act = (state_reg == S_IDLE) && !go_sleep && !dirty_reg && !ref_due_reg
		&& (op_reg == OP_WRITE || (op_reg == OP_READ && free >= beats)); // [RL3]

	sync_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) rx_fifo (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_in_valid(push),
		.o_in_ready(),
		.i_in_data(m.dq),
		.o_out_valid(),
		.i_out_ready(pop),
		.o_out_data(head),
		.o_level(level)
	);

	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			op_reg <= '0;
			addr_reg <= '0;
			wdata_reg <= '0;
			cfg_reg <= CFG_RESET;
		end
		else
		begin
			if (go_act)
				op_reg <= '0;
			else if (i_wr && i_addr == REG_CMD && op_reg == '0)
				op_reg <= i_wdata[1:0];
			if (i_wr && i_addr == REG_ADDR)
				addr_reg <= i_wdata;
			if (i_wr && i_addr == REG_WDATA)
				wdata_reg <= i_wdata[DATA_W-1:0];
			if (i_wr && i_addr == REG_CFG)
				cfg_reg <= i_wdata;
		end
	end

	// Pending flags: a new set wins over the clear of the same cycle
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			dirty_reg <= 1'b1;
			ref_due_reg <= 1'b0;
			ref_cnt_reg <= '0;
		end
		else
		begin
			if (i_wr && i_addr == REG_CFG)
				dirty_reg <= 1'b1;
			else if (go_lmr)
				dirty_reg <= 1'b0;
			if (state_reg == S_SLEEP || ref_cnt_reg == BEAT_W'(REFRESH_CYCLES - 1))
				ref_cnt_reg <= '0;
			else
				ref_cnt_reg <= ref_cnt_reg + 1'b1;
			if (state_reg != S_SLEEP && ref_cnt_reg == BEAT_W'(REFRESH_CYCLES - 1))
				ref_due_reg <= 1'b1; // [RL10]
			else if (go_ref || go_sleep)
				ref_due_reg <= 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			state_reg <= S_IDLE;
			cmd_reg <= CMD_NOP;
			cke_reg <= 1'b1;
			ba_reg <= '0;
			a_reg <= '0;
			dq_o_reg <= '0;
			dq_oe_reg <= 1'b0;
			cnt_reg <= '0;
			is_rd_reg <= 1'b0;
		end
		else
		begin
			cmd_reg <= CMD_NOP; // [RL14]
			dq_oe_reg <= 1'b0;
			cnt_reg <= cnt_reg + 1'b1;
			case (state_reg)
				S_IDLE:
				begin
					if (go_sleep)
					begin
						cmd_reg <= CMD_REF;
						cke_reg <= 1'b0;
						state_reg <= S_SLEEP;
					end
					else if (go_lmr)
					begin
						cmd_reg <= CMD_LMR;
						a_reg <= '0;
						a_reg[MODE_BL_LSB +: 3] <= cfg_reg[2:0];
						a_reg[MODE_CL_LSB +: 3] <= cfg_reg[CFG_CL3_BIT] ? CL_3 : CL_2; // [RL13]
					end
					else if (go_ref)
						cmd_reg <= CMD_REF;
					else if (go_act)
					begin
						cmd_reg <= CMD_ACT; // [RL3]
						ba_reg <= addr_reg[ADDR_BANK_LSB +: BANK_W];
						a_reg <= addr_reg[ADDR_ROW_LSB +: ROW_W];
						is_rd_reg <= (op_reg == OP_READ);
						state_reg <= S_ACT;
					end
				end
				S_ACT:
				begin
					cmd_reg <= is_rd_reg ? CMD_RD : CMD_WR; // [RL9]
					a_reg <= '0;
					a_reg[COL_W-1:0] <= addr_reg[COL_W-1:0];
					a_reg[AP_BIT] <= 1'b1; // [RL11]
					dq_o_reg <= wdata_reg;
					dq_oe_reg <= !is_rd_reg;
					cnt_reg <= 10'h001;
					state_reg <= S_RUN;
				end
				S_RUN:
				begin
					if (!is_rd_reg)
					begin
						if (beats != 10'h001)
							cmd_reg <= CMD_BST;
						state_reg <= S_IDLE;
					end
					else
					begin
						if (cfg_reg[2:0] == BL_PAGE && cnt_reg == PAGE_READ_BEATS)
							cmd_reg <= CMD_BST;
						if (push && got_reg + 1'b1 == beats)
							state_reg <= S_IDLE; // [RL13]
					end
				end
				S_SLEEP:
					if (!cfg_reg[CFG_SLEEP_BIT])
					begin
						cke_reg <= 1'b1;
						state_reg <= S_IDLE;
					end
				default:
					state_reg <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			got_reg <= '0;
		else if (state_reg == S_ACT)
			got_reg <= '0;
		else if (push)
			got_reg <= got_reg + 1'b1;
	end

	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			rdata_reg <= '0;
		else if (i_rd)
		begin
			case (i_addr)
				REG_ADDR: rdata_reg <= addr_reg;
				REG_WDATA: rdata_reg <= 32'(wdata_reg);
				REG_CFG: rdata_reg <= cfg_reg;
				REG_RDATA: rdata_reg <= 32'(head);
				REG_STATUS: rdata_reg <= (32'(level) << STAT_LEVEL_LSB)
					| (32'(state_reg == S_SLEEP) << STAT_SLEEP_BIT)
					| 32'(state_reg != S_IDLE || op_reg != '0);
				default: rdata_reg <= '0;
			endcase
		end
	end

	assign m.cs_n = 1'b0; // [RL1]
	assign {m.ras_n, m.cas_n, m.we_n} = cmd_reg;
	assign m.cke = cke_reg;
	assign {m.bank_select_1, m.bank_select_0} = ba_reg;
	assign m.addr = a_reg;
	assign m.low_byte_mask = 1'b0;
	assign m.high_byte_mask = 1'b0;
	assign m.ctl_dq_o = dq_o_reg;
	assign m.ctl_dq_oe = dq_oe_reg;
	assign o_rdata = rdata_reg;
endmodule

// >>> testbench/sdram_asserts.sv
// Checker for the pin bundle between the SDRAM controller and device.
// Takes the bundle's signals as plain inputs; one clock, async active-low reset.
`timescale 1ns/1ps
module sdram_asserts
	import sdram_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic cke,
	input wire logic bank_select_0,
	input wire logic bank_select_1,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic ctl_dq_oe,
	input wire logic dev_dq_oe
);
	logic [2:0] cmd;
	logic col_cmd;
	logic [2:0] bl_reg;
	logic [2:0] cl_reg;
	logic [4:0] beat_reg;
	logic [10:0] ref_reg;
	logic [4:0] lim;
	assign cmd = {ras_n, cas_n, we_n};
	assign col_cmd = (cmd == CMD_RD) || (cmd == CMD_WR);
	assign lim = (bl_reg == BL_PAGE) ? 5'h10 : (5'h01 << bl_reg);
	// Mode as last loaded
	always_ff @(posedge i_clk or negedge i_nrst)
		if (!i_nrst)
		begin
			bl_reg <= BL_1;
			cl_reg <= CL_2;
		end
		else if (cmd == CMD_LMR)
		begin
			bl_reg <= addr[2:0];
			cl_reg <= addr[6:4];
		end
	// Read beats in the current burst
	always_ff @(posedge i_clk or negedge i_nrst)
		if (!i_nrst)
			beat_reg <= 5'h00;
		else
			beat_reg <= dev_dq_oe ? beat_reg + 5'h01 : 5'h00;
	// Awake cycles since the last refresh
	always_ff @(posedge i_clk or negedge i_nrst)
		if (!i_nrst)
			ref_reg <= 11'h000;
		else if (cmd == CMD_REF)
			ref_reg <= 11'h000;
		else if (cke)
			ref_reg <= ref_reg + 11'h001;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_nrst);
	a_select_tied: assert property (cs_n == 1'b0)
		else $error("chip select not low");
	a_col_after_act: assert property (col_cmd |->
		$past(cmd) == CMD_ACT && $stable({bank_select_1, bank_select_0}))
		else $error("column command without activate of that bank");
	a_auto_pre: assert property (col_cmd |-> addr[AP_BIT])
		else $error("column command without auto precharge");
	a_write_drive: assert property (cmd == CMD_WR |-> ctl_dq_oe ##1 !ctl_dq_oe)
		else $error("write data not driven with write command");
	a_write_stop: assert property (cmd == CMD_WR && bl_reg != BL_1 |=> cmd == CMD_BST)
		else $error("write burst not terminated");
	a_lat_two: assert property (cmd == CMD_RD && cl_reg == CL_2 |->
		##1 !dev_dq_oe ##1 dev_dq_oe)
		else $error("read data not at latency two");
	a_lat_three: assert property (cmd == CMD_RD && cl_reg == CL_3 |->
		##1 !dev_dq_oe [*2] ##1 dev_dq_oe)
		else $error("read data not at latency three");
	a_burst_count: assert property ($fell(dev_dq_oe) |-> beat_reg == lim)
		else $error("read burst length wrong");
	a_no_fight: assert property (!(ctl_dq_oe && dev_dq_oe))
		else $error("both ends drive data bus");
	a_sleep_entry: assert property ($fell(cke) |-> cmd == CMD_REF)
		else $error("clock enable dropped without refresh");
	a_refresh_due: assert property (ref_reg <= REFRESH_CYCLES + 64)
		else $error("refresh interval exceeded");
	c_read_cl3: cover property (cmd == CMD_RD && cl_reg == CL_3);
	c_sleep: cover property ($fell(cke));
	c_page_stop: cover property (cmd == CMD_BST && bl_reg == BL_PAGE);
	c_refresh: cover property (cmd == CMD_REF && cke);
endmodule

// >>> testbench/tb_quad_bank_sdram_access.sv
// Bench for the SDRAM controller and device joined by their pin bundle.
// Drives the software port at rising edges; checker sits beside the bundle.
`timescale 1ns/1ps
module tb_quad_bank_sdram_access;
	import sdram_pkg::*;
	typedef struct {
		logic [31:0] cfg;
		logic [31:0] addr;
		logic [15:0] data;
		logic [4:0] lvl;
	} row_t;
	logic i_clk;
	logic i_nrst;
	logic [7:0] i_addr;
	logic [31:0] i_wdata;
	logic i_wr;
	logic i_rd;
	logic [31:0] o_rdata;
	logic o_self_refresh;
	logic [31:0] d;
	int err_total;
	int tests_run;
	row_t rows [7];
	sdram_if bus ();
	sdram_ctl sdram_ctl_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .m(bus));
	sdram_mem sdram_mem_i (.i_clk(i_clk), .i_nrst(i_nrst),
		.o_self_refresh(o_self_refresh), .m(bus));
	sdram_asserts sdram_asserts_i (.i_clk(i_clk), .i_nrst(i_nrst), .cs_n(bus.cs_n),
		.ras_n(bus.ras_n), .cas_n(bus.cas_n), .we_n(bus.we_n), .cke(bus.cke),
		.bank_select_0(bus.bank_select_0), .bank_select_1(bus.bank_select_1),
		.addr(bus.addr), .ctl_dq_oe(bus.ctl_dq_oe), .dev_dq_oe(bus.dev_dq_oe));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		if (err_total == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= v;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 v = o_rdata;
	endtask
	task automatic wait_stat(input int b, input logic v);
		logic [31:0] s;
		for (int k = 0; k < 300; k++)
		begin
			rd(REG_STATUS, s);
			if (s[b] === v)
				return;
		end
		err_total++;
		$display("unexpected at %0t: status wait ran out", $time);
		finish_test();
	endtask
	task automatic set_cfg(input logic [31:0] v);
		wr(REG_CFG, v);
		wait_stat(0, 1'b0);
	endtask
	task automatic put_word(input logic [31:0] a, input logic [15:0] v);
		wr(REG_ADDR, a);
		wr(REG_WDATA, {16'h0000, v});
		wr(REG_CMD, {30'h0, OP_WRITE});
		wait_stat(0, 1'b0);
	endtask
	task automatic get_burst(input logic [31:0] a);
		wr(REG_ADDR, a);
		wr(REG_CMD, {30'h0, OP_READ});
		wait_stat(0, 1'b0);
	endtask
	initial
	begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	initial
	begin
		rows[0] = '{32'h0000_0000, 32'h0000_0A03, 16'h1234, 5'h01};
		rows[1] = '{32'h0000_0001, 32'h0020_0C10, 16'h5A5A, 5'h02};
		rows[2] = '{32'h0000_0002, 32'h0040_0E21, 16'h0F0F, 5'h04};
		rows[3] = '{32'h0000_0003, 32'h0060_1042, 16'hC3C3, 5'h08};
		rows[4] = '{32'h0000_0007, 32'h0000_1280, 16'h8001, 5'h10};
		rows[5] = '{32'h0000_0010, 32'h0020_1401, 16'h7E7E, 5'h01};
		rows[6] = '{32'h0000_0012, 32'h0060_1605, 16'h3C3C, 5'h04};
		err_total = 0;
		tests_run = 0;
		i_nrst = 1'b0;
		i_addr = 8'h00;
		i_wdata = 32'h0000_0000;
		i_wr = 1'b0;
		i_rd = 1'b0;
		repeat (3) @(posedge i_clk);
		chk(bus.cke, 1'b1);
		chk(bus.dev_dq_oe, 1'b0);
		chk(o_rdata, 32'h0000_0000);
		i_nrst <= 1'b1;
		// Every burst code and both latencies
		foreach (rows[n])
		begin
			set_cfg(rows[n].cfg);
			put_word(rows[n].addr, rows[n].data);
			get_burst(rows[n].addr);
			rd(REG_STATUS, d);
			chk(d[8:4], rows[n].lvl);
			rd(REG_RDATA, d);
			chk(d, {16'h0000, rows[n].data});
			for (int k = 1; k < rows[n].lvl; k++)
				rd(REG_RDATA, d);
			rd(REG_STATUS, d);
			chk(d[8:4], 5'h00);
		end
		// Burst wraps inside its aligned block
		set_cfg(32'h0000_0000);
		for (int i = 0; i < 4; i++)
			put_word(32'h0040_0000 | i, 16'(16'h00A0 + i));
		set_cfg(32'h0000_0002);
		get_burst(32'h0040_0002);
		for (int i = 0; i < 4; i++)
		begin
			rd(REG_RDATA, d);
			chk(d, 32'h0000_00A0 + ((i + 2) % 4));
		end
		rd(8'h20, d);
		chk(d, 32'h0000_0000);
		// Self refresh keeps contents
		wr(REG_CFG, 32'h0000_0100);
		wait_stat(STAT_SLEEP_BIT, 1'b1);
		repeat (40) @(posedge i_clk);
		chk(o_self_refresh, 1'b1);
		chk(bus.cke, 1'b0);
		wr(REG_CFG, 32'h0000_0000);
		wait_stat(STAT_SLEEP_BIT, 1'b0);
		wait_stat(0, 1'b0);
		chk(o_self_refresh, 1'b0);
		get_burst(rows[0].addr);
		rd(REG_RDATA, d);
		chk(d, {16'h0000, rows[0].data});
		// Idle past a refresh interval; contents kept
		repeat (800) @(posedge i_clk);
		get_burst(rows[5].addr);
		rd(REG_RDATA, d);
		chk(d, {16'h0000, rows[5].data});
		// Reset in mid-run, then a read from the fresh state
		@(posedge i_clk);
		i_nrst <= 1'b0;
		repeat (2) @(posedge i_clk);
		chk(bus.ctl_dq_oe, 1'b0);
		chk(bus.cke, 1'b1);
		chk(o_self_refresh, 1'b0);
		chk(o_rdata, 32'h0000_0000);
		i_nrst <= 1'b1;
		rd(REG_STATUS, d);
		chk(d, 32'h0000_0000);
		rd(REG_CFG, d);
		chk(d, CFG_RESET);
		get_burst(rows[0].addr);
		rd(REG_RDATA, d);
		chk(d, {16'h0000, rows[0].data});
		finish_test();
	end
endmodule
